// >>> src/cpu8_pkg.sv
// package for the 8-bit core subset: opcodes, vectors, timing counts
// assumes a single 50 MHz system clock and byte-wide memory bus
package cpu8_pkg;
   // ==========================================
   // opcodes
   localparam logic [7:0] OP_PREFIX  = 8'h9E;
   localparam logic [7:0] OP_LSR_DIR = 8'h34;
   localparam logic [7:0] OP_LSR_A   = 8'h44;
   localparam logic [7:0] OP_LSR_X   = 8'h54;
   localparam logic [7:0] OP_LSR_IX1 = 8'h64;
   localparam logic [7:0] OP_LSR_IX  = 8'h74;
   localparam logic [7:0] OP_MOV_DD  = 8'h4E;
   localparam logic [7:0] OP_MOV_DIX = 8'h5E;
   localparam logic [7:0] OP_MOV_IMD = 8'h6E;
   localparam logic [7:0] OP_MOV_IXD = 8'h7E;
   localparam logic [7:0] OP_MUL     = 8'h42;
   localparam logic [7:0] OP_NEG_DIR = 8'h30;
   localparam logic [7:0] OP_NEG_A   = 8'h40;
   localparam logic [7:0] OP_NEG_X   = 8'h50;
   localparam logic [7:0] OP_NEG_IX1 = 8'h60;
   localparam logic [7:0] OP_NEG_IX  = 8'h70;
   localparam logic [7:0] OP_NSA     = 8'h62;
   localparam logic [7:0] OP_ORA_IMM = 8'hAA;
   localparam logic [7:0] OP_ORA_DIR = 8'hBA;
   localparam logic [7:0] OP_ORA_EXT = 8'hCA;
   localparam logic [7:0] OP_ORA_IX2 = 8'hDA;
   localparam logic [7:0] OP_ORA_IX1 = 8'hEA;
   localparam logic [7:0] OP_ORA_IX  = 8'hFA;
   localparam logic [7:0] OP_PUSH_ACCUMULATOR_OP    = 8'h87;
   localparam logic [7:0] OP_PUSH_INDEX_HIGH_OP    = 8'h8B;
   localparam logic [7:0] OP_PUSH_INDEX_LOW_OP    = 8'h89;
   localparam logic [7:0] OP_PULL_ACCUMULATOR_OP    = 8'h86;
   localparam logic [7:0] OP_PULL_INDEX_HIGH_OP    = 8'h8A;
   localparam logic [7:0] OP_PULL_INDEX_LOW_OP    = 8'h88;
   localparam logic [7:0] OP_ROL_DIR = 8'h39;
   localparam logic [7:0] OP_ROL_A   = 8'h49;
   localparam logic [7:0] OP_ROL_X   = 8'h59;
   localparam logic [7:0] OP_ROL_IX1 = 8'h69;
   localparam logic [7:0] OP_ROL_IX  = 8'h79;
   localparam logic [7:0] OP_SWI     = 8'h83;
   localparam logic [7:0] OP_RTI     = 8'h80;
   localparam logic [7:0] OP_STOP    = 8'h8E;
   // ==========================================
   // vectors and reset values
   localparam logic [15:0] VEC_BREAK     = 16'hFFFC;
   localparam logic [15:0] VEC_BREAK_MON = 16'hFEFC;
   localparam logic [15:0] SP_RESET      = 16'h00FF;
   localparam logic [7:0]  ZERO_BYTE     = 8'h00;
   // ==========================================
   // cycle counts
   localparam int CYC_MOV_DD = 5;
   localparam int CYC_MOV    = 4;
   localparam int CYC_MUL    = 5;
   localparam int CYC_NSA    = 3;
   localparam int CYC_STACK  = 2;
   localparam int CYC_INH    = 1;
   // oscillator stabilization delay
   localparam int CLK_MHZ       = 50;
   localparam int OSC_STAB_US   = 100;
   localparam int OSC_STAB_CYC  = OSC_STAB_US * CLK_MHZ;
   // ==========================================
   // flag positions in the 6-bit flag word {v,h,i,n,z,c} -> index
   localparam int FL_C = 0;
   localparam int FL_Z = 1;
   localparam int FL_N = 2;
   localparam int FL_I = 3;
   localparam int FL_H = 4;
   localparam int FL_V = 5;
   localparam int FLAG_W = 6;
endpackage : cpu8_pkg

// >>> src/cpu8_alu.sv
// combinational byte ALU for the shift, rotate, negate, or and multiply ops
// assumes the caller registers its results
`timescale 1ns/1ns
module cpu8_alu (
   input  wire logic [2:0]  func_in,
   input  wire logic [7:0]  a_in,
   input  wire logic [7:0]  b_in,
   input  wire logic        carry_in,
   output logic      [15:0] result_out,
   output logic             c_out,
   output logic             v_out
);
   // func: 0 lsr, 1 rol, 2 neg, 3 or, 4 mul, 5 pass, 6 nsa
   wire [15:0] prod  = {8'h00, a_in} * {8'h00, b_in};
   wire [7:0]  neg_r = cpu8_pkg::ZERO_BYTE - a_in;
   wire [7:0]  lsr_r = {1'b0, a_in[7:1]};
   wire [7:0]  rol_r = {a_in[6:0], carry_in};
   always_comb begin
      result_out = {8'h00, a_in};
      c_out      = carry_in;
      v_out      = 1'b0;
      case (func_in)
         3'd0: begin
            result_out = {8'h00, lsr_r};
            c_out      = a_in[0];
            v_out      = a_in[0];          // n(=0) xor c
         end
         3'd1: begin
            result_out = {8'h00, rol_r};
            c_out      = a_in[7];
            v_out      = rol_r[7] ^ a_in[7];
         end
         3'd2: begin
            result_out = {8'h00, neg_r};
            c_out      = (neg_r != 8'h00);
            v_out      = (neg_r == 8'h80);
         end
         3'd3: result_out = {8'h00, a_in | b_in};
         3'd4: begin
            result_out = prod;
            c_out      = 1'b0;
         end
         3'd6: result_out = {8'h00, a_in[3:0], a_in[7:4]};
         default: result_out = {8'h00, a_in};
      endcase
   end
endmodule : cpu8_alu

// >>> src/cpu8_stab.sv
// oscillator stabilization counter for stop-mode exit
// assumes start_in is a one-cycle pulse
`timescale 1ns/1ns
module cpu8_stab #(
   parameter int COUNT = cpu8_pkg::OSC_STAB_CYC
) (
   input  wire logic clk_sys_in,
   input  wire logic reset_in,
   input  wire logic ce_in,
   input  wire logic start_in,
   output logic      done_out
);
   if (COUNT < 1) begin : g_count_check
      $error("stabilization count must be at least one");
   end
   logic [31:0] cnt;
   logic        busy;
   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         cnt      <= 32'h0000_0000;
         busy     <= 1'b0;
         done_out <= 1'b0;
      end else if (ce_in) begin
         done_out <= 1'b0;
         if (start_in) begin
            cnt  <= 32'h0000_0000;
            busy <= 1'b1;
         end else if (busy) begin
            cnt <= cnt + 32'h0000_0001;
            if (cnt == 32'(COUNT - 1)) begin
               busy     <= 1'b0;
               done_out <= 1'b1;
            end
         end
      end
   end
endmodule : cpu8_stab

// >>> src/cpu8_core.sv
// decoder and executer for a subset of the 8-bit core, plus stop and break
// assumes fetched operand and stack read data arrive ready on operand_in
// Summary of operation
// RL1: an 8-bit accumulator holds operands and takes arithmetic and logic results
// RL2: stop clears the interrupt mask and halts the cpu clock
// RL3: interrupt exit keeps mask clear; reset exit sets the mask
// RL4: clock restarts only after oscillator stabilization delay
// RL5: break loads software interrupt opcode and break vector, alternate in monitor
// RL6: break starts after current instruction, at once if match on last cycle
// RL7: return from interrupt ends break once the break request is gone
// RL8: shift right inserts zero, bit 0 to carry, clears n
// RL9: move copies byte, clears v; post-increment forms bump h:x
// RL10: multiply puts x times a into x:a, clears h and c
// RL11: negate forms zero minus operand, updates v n z c
// RL12: nibble swap exchanges halves of a, flags unchanged
// RL13: or writes a or operand into a, clears v
// RL14: push stores register at stack pointer then decrements it
// RL15: pull increments stack pointer then loads the register
// RL16: rotate left moves carry into bit 0 and bit 7 to carry
// RL17: other opcodes pass to the rest of the core untouched
`timescale 1ns/1ns
module cpu8_core #(
   parameter int STAB_CYCLES = cpu8_pkg::OSC_STAB_CYC
) (
   input  wire logic        clk_sys_in,
   input  wire logic        reset_in,
   input  wire logic        ce_in,
   input  wire logic        op_valid_in,
   input  wire logic [7:0]  opcode_in,
   input  wire logic        prefix_in,
   input  wire logic [7:0]  operand_in,
   input  wire logic [15:0] ea_in,
   input  wire logic [15:0] ea2_in,
   input  wire logic        last_cycle_in,
   input  wire logic        break_req_in,
   input  wire logic        monitor_in,
   input  wire logic        ext_irq_in,
   output logic             busy_out,
   output logic [7:0]       acc_out,
   output logic [7:0]       x_out,
   output logic [7:0]       h_out,
   output logic [15:0]      stack_pointer_out,
   output logic [5:0]       flags_out,
   output logic [15:0]      pc_out,
   output logic             pc_load_out,
   output logic [7:0]       ir_out,
   output logic             mem_we_out,
   output logic [15:0]      mem_addr_out,
   output logic [7:0]       mem_wdata_out,
   output logic             cpu_clk_en_out,
   output logic             in_break_out,
   output logic             pass_op_out,
   output logic [7:0]       pass_opcode_out
);
   typedef enum logic [2:0] {S_IDLE, S_EXEC, S_STOP, S_STAB} cpu8_st_e;
   cpu8_st_e   st;
   logic [7:0] acc, xr, hr;
   logic [15:0] sp;
   logic [5:0] fl;
   logic [3:0] cyc;
   logic [3:0] cyc_total;
   logic [7:0] op;
   logic       pre;
   logic       brk_pend;
   logic       stab_go;
   wire        stab_done;

   // ==========================================
   // decode
   function automatic logic [2:0] alu_sel(input logic [7:0] o);
      case (o[7:4] == 4'h9 ? 4'h0 : o[3:0])
         4'h4: alu_sel = 3'd0;
         4'h9: alu_sel = 3'd1;
         4'h0: alu_sel = 3'd2;
         4'hA: alu_sel = 3'd3;
         4'h2: alu_sel = (o == cpu8_pkg::OP_MUL) ? 3'd4 : 3'd6;
         default: alu_sel = 3'd5;
      endcase
   endfunction
   function automatic logic in_grp(input logic [7:0] o, input logic [3:0] lo);
      in_grp = (o[3:0] == lo) && (o[7:4] >= 4'h3) && (o[7:4] <= 4'h7);
   endfunction

   wire is_lsr  = in_grp(opcode_in, 4'h4) && (!prefix_in || opcode_in == cpu8_pkg::OP_LSR_IX1);
   wire is_rol  = in_grp(opcode_in, 4'h9) && (!prefix_in || opcode_in == cpu8_pkg::OP_ROL_IX1);
   wire is_neg  = in_grp(opcode_in, 4'h0) && (!prefix_in || opcode_in == cpu8_pkg::OP_NEG_IX1);
   wire is_mov  = (opcode_in[3:0] == 4'hE) && (opcode_in[7:4] >= 4'h4)
                  && (opcode_in[7:4] <= 4'h7) && !prefix_in;
   wire is_mul  = (opcode_in == cpu8_pkg::OP_MUL) && !prefix_in;
   wire is_nsa  = (opcode_in == cpu8_pkg::OP_NSA) && !prefix_in;
   wire is_ora  = (opcode_in[3:0] == 4'hA) && (opcode_in[7:4] >= 4'hA)
                  && (!prefix_in || opcode_in == cpu8_pkg::OP_ORA_IX1
                      || opcode_in == cpu8_pkg::OP_ORA_IX2);
   wire is_push = !prefix_in && (opcode_in == cpu8_pkg::OP_PUSH_ACCUMULATOR_OP
                  || opcode_in == cpu8_pkg::OP_PUSH_INDEX_HIGH_OP || opcode_in == cpu8_pkg::OP_PUSH_INDEX_LOW_OP);
   wire is_pull = !prefix_in && (opcode_in == cpu8_pkg::OP_PULL_ACCUMULATOR_OP
                  || opcode_in == cpu8_pkg::OP_PULL_INDEX_HIGH_OP || opcode_in == cpu8_pkg::OP_PULL_INDEX_LOW_OP);
   wire is_stop = !prefix_in && opcode_in == cpu8_pkg::OP_STOP;
   wire is_rti  = !prefix_in && opcode_in == cpu8_pkg::OP_RTI;
   wire is_ours = is_lsr | is_rol | is_neg | is_mov | is_mul | is_nsa | is_ora
                  | is_push | is_pull | is_stop | is_rti;
   // inherent forms work on a (4x) or x (5x)
   wire on_a    = !prefix_in && opcode_in[7:4] == 4'h4;
   wire on_x    = !prefix_in && opcode_in[7:4] == 4'h5;
   // a starting break refuses the offered opcode, so no half-executed op is left behind
   wire take    = ce_in && st == S_IDLE && op_valid_in && !brk_start;

   // ==========================================
   // alu
   wire [7:0]  alu_a = is_mul ? xr : (on_a || is_ora || is_nsa) ? acc : on_x ? xr : operand_in;
   wire [7:0]  alu_b = is_mul ? acc : operand_in;
   wire [15:0] alu_res;
   wire        alu_c, alu_v;
   cpu8_alu u_alu (
      .func_in    (alu_sel(opcode_in)),
      .a_in       (alu_a),
      .b_in       (alu_b),
      .carry_in   (fl[cpu8_pkg::FL_C]),
      .result_out (alu_res),
      .c_out      (alu_c),
      .v_out      (alu_v)
   );
   wire [7:0] res8  = is_mov ? operand_in : alu_res[7:0];
   wire       res_z = (res8 == 8'h00);
   wire [15:0] hx_inc = {hr, xr} + 16'h0001;

   // next flags
   logic [5:0] next_fl;
   always_comb begin
      next_fl = fl;
      if (is_lsr || is_rol || is_neg) begin
         next_fl[cpu8_pkg::FL_C] = alu_c;                          // RL8 RL11 RL16
         next_fl[cpu8_pkg::FL_V] = is_lsr ? alu_c : alu_v;
         next_fl[cpu8_pkg::FL_N] = is_lsr ? 1'b0 : res8[7];
         next_fl[cpu8_pkg::FL_Z] = res_z;
      end else if (is_mov || is_ora) begin
         next_fl[cpu8_pkg::FL_V] = 1'b0;                           // RL9 RL13
         next_fl[cpu8_pkg::FL_N] = res8[7];
         next_fl[cpu8_pkg::FL_Z] = res_z;
      end else if (is_mul) begin
         next_fl[cpu8_pkg::FL_H] = 1'b0;                           // RL10
         next_fl[cpu8_pkg::FL_C] = 1'b0;
      end else if (is_stop) begin
         next_fl[cpu8_pkg::FL_I] = 1'b0;                           // RL2
      end
   end

   wire [3:0] next_total = is_mov ? ((opcode_in == cpu8_pkg::OP_MOV_DD) ? 4'(cpu8_pkg::CYC_MOV_DD)
                                                                       : 4'(cpu8_pkg::CYC_MOV))
                         : is_mul ? 4'(cpu8_pkg::CYC_MUL)
                         : is_nsa ? 4'(cpu8_pkg::CYC_NSA)
                         : (is_push || is_pull) ? 4'(cpu8_pkg::CYC_STACK)
                         : 4'(cpu8_pkg::CYC_INH);
   wire exec_end = st == S_EXEC && cyc == cyc_total - 4'd1;
   wire brk_start = ce_in && (brk_pend || break_req_in)
                    && (st == S_IDLE || exec_end) && !in_break_out;   // RL6

   // ==========================================
   // architectural state
   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         acc <= 8'h00;
         xr  <= 8'h00;
         hr  <= 8'h00;
         sp  <= cpu8_pkg::SP_RESET;
         fl  <= 6'b00_1000;                                          // RL3
      end else if (take) begin
         fl <= next_fl;
         if (is_mul) begin
            {xr, acc} <= alu_res;                                     // RL10
         end else if ((is_lsr || is_rol || is_neg) && on_a) begin
            acc <= res8;                                              // RL1
         end else if ((is_lsr || is_rol || is_neg) && on_x) begin
            xr <= res8;
         end else if (is_ora || is_nsa) begin
            acc <= alu_res[7:0];                                      // RL13 RL12
         end else if (is_mov && (opcode_in == cpu8_pkg::OP_MOV_DIX
                                 || opcode_in == cpu8_pkg::OP_MOV_IXD)) begin
            {hr, xr} <= hx_inc;                                       // RL9
         end else if (is_push) begin
            sp <= sp - 16'h0001;                                      // RL14
         end else if (is_pull) begin
            sp <= sp + 16'h0001;                                      // RL15
            if (opcode_in == cpu8_pkg::OP_PULL_ACCUMULATOR_OP) acc <= operand_in;
            else if (opcode_in == cpu8_pkg::OP_PULL_INDEX_HIGH_OP) hr <= operand_in;
            else xr <= operand_in;
         end
      end
   end

   // ==========================================
   // memory write path
   wire [7:0] push_data = (opcode_in == cpu8_pkg::OP_PUSH_ACCUMULATOR_OP) ? acc
                        : (opcode_in == cpu8_pkg::OP_PUSH_INDEX_HIGH_OP) ? hr : xr;
   wire mem_wr = take && (is_push || is_mov || ((is_lsr || is_rol || is_neg) && !on_a && !on_x));
   wire [15:0] wr_addr = is_push ? sp : is_mov ? ea2_in : ea_in;
   wire [7:0]  wr_data = is_push ? push_data : res8;
   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         mem_we_out    <= 1'b0;
         mem_addr_out  <= 16'h0000;
         mem_wdata_out <= 8'h00;
      end else if (ce_in) begin
         mem_we_out <= mem_wr;                                        // RL14
         if (mem_wr) begin
            mem_addr_out  <= wr_addr;
            mem_wdata_out <= wr_data;
         end
      end
   end

   // ==========================================
   // sequencing, stop and break
   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         st              <= S_IDLE;
         cyc             <= 4'd0;
         cyc_total       <= 4'd1;
         brk_pend        <= 1'b0;
         in_break_out    <= 1'b0;
         pc_out          <= 16'h0000;
         pc_load_out     <= 1'b0;
         ir_out          <= 8'h00;
         cpu_clk_en_out  <= 1'b1;
         stab_go         <= 1'b0;
         pass_op_out     <= 1'b0;
         pass_opcode_out <= 8'h00;
      end else if (ce_in) begin
         pc_load_out <= 1'b0;
         stab_go     <= 1'b0;
         pass_op_out <= take && !is_ours;                             // RL17
         if (take && !is_ours) pass_opcode_out <= opcode_in;
         if (break_req_in && !in_break_out) brk_pend <= 1'b1;
         if (brk_start) begin
            ir_out       <= cpu8_pkg::OP_SWI;                         // RL5
            pc_out       <= monitor_in ? cpu8_pkg::VEC_BREAK_MON : cpu8_pkg::VEC_BREAK;
            pc_load_out  <= 1'b1;
            in_break_out <= 1'b1;
            brk_pend     <= 1'b0;
         end
         case (st)
            S_IDLE: begin
               if (take && !brk_start) begin
                  if (is_rti && in_break_out && !break_req_in) begin
                     in_break_out <= 1'b0;                            // RL7
                  end
                  if (is_stop) begin
                     st             <= S_STOP;
                     cpu_clk_en_out <= 1'b0;                          // RL2
                  end else if (is_ours && next_total > 4'd1) begin
                     st        <= S_EXEC;
                     cyc       <= 4'd1;
                     cyc_total <= next_total;
                  end
               end
            end
            S_EXEC: begin
               cyc <= cyc + 4'd1;
               if (exec_end) st <= S_IDLE;
            end
            S_STOP: begin
               if (ext_irq_in || break_req_in) begin
                  st      <= S_STAB;
                  stab_go <= 1'b1;
               end
            end
            S_STAB: begin
               if (stab_done) begin
                  st             <= S_IDLE;
                  cpu_clk_en_out <= 1'b1;                             // RL4
               end
            end
            default: st <= S_IDLE;
         endcase
      end
   end

   cpu8_stab #(.COUNT(STAB_CYCLES)) u_stab (
      .clk_sys_in (clk_sys_in),
      .reset_in   (reset_in),
      .ce_in      (ce_in),
      .start_in   (stab_go),
      .done_out   (stab_done)
   );

   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         busy_out <= 1'b0;
      end else if (ce_in) begin
         busy_out <= (st != S_IDLE);
      end
   end
   assign acc_out           = acc;
   assign x_out             = xr;
   assign h_out             = hr;
   assign stack_pointer_out = sp;
   assign flags_out         = fl;

   // ==========================================
   // checks
   sequence s_stop_taken;
      take && is_stop;
   endsequence
   chk_stop_mask: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      s_stop_taken |=> !fl[cpu8_pkg::FL_I] && !cpu_clk_en_out)            // RL2
      else $error("stop did not clear mask or halt clock");
   chk_stop_irq: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      st == S_STOP |-> !fl[cpu8_pkg::FL_I])                                // RL3
      else $error("mask set during stop");
   chk_clk_restart: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      $rose(cpu_clk_en_out) |-> $past(stab_done))                         // RL4
      else $error("clock restarted before stabilization");
   chk_break_vec: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      $rose(in_break_out) |-> ir_out == cpu8_pkg::OP_SWI && pc_load_out
         && pc_out == (monitor_in ? cpu8_pkg::VEC_BREAK_MON : cpu8_pkg::VEC_BREAK)) // RL5
      else $error("break vector wrong");
   chk_break_wait: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      ce_in && st == S_EXEC && !exec_end |=> !$rose(in_break_out))          // RL6
      else $error("break started mid instruction");
   chk_rti_end: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      $fell(in_break_out) |-> !$past(break_req_in))                        // RL7
      else $error("break ended with request active");
   chk_mul_result: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      take && is_mul |=> {xr, acc} == $past(xr) * $past(acc)
         && !fl[cpu8_pkg::FL_C] && !fl[cpu8_pkg::FL_H])                      // RL10
      else $error("multiply result wrong");
   chk_nsa_swap: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      take && is_nsa |=> acc == {$past(acc[3:0]), $past(acc[7:4])} && fl == $past(fl)) // RL12
      else $error("nibble swap wrong");
   chk_push_sp: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      take && is_push |=> sp == $past(sp) - 16'h0001 && mem_we_out
         && mem_addr_out == $past(sp))                                        // RL14
      else $error("push wrong");
   chk_pass_through: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      take && !is_ours |=> pass_op_out && acc == $past(acc) && sp == $past(sp)) // RL17
      else $error("foreign opcode altered state");
endmodule : cpu8_core

// >>> testbench/cpu8_mem_model.sv
// byte memory on the core's bus side: takes write pulses, answers reads at once
// assumes single-cycle write strobes on the system clock, low 8 address bits
`timescale 1ns/1ns
module cpu8_mem_model (
   input  wire logic        clk_sys_in,
   input  wire logic        we_in,
   input  wire logic [15:0] addr_in,
   input  wire logic [7:0]  wdata_in,
   input  wire logic [15:0] rd_addr_in,
   output logic      [7:0]  rd_data_out
);
   logic [7:0] mem [0:255];
   // unwritten places hold a varied pattern so a stale zero cannot pass
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'hA5;
   end
   always @(posedge clk_sys_in) begin
      if (we_in === 1'b1) mem[addr_in[7:0]] <= wdata_in;
   end
   assign rd_data_out = mem[rd_addr_in[7:0]];
endmodule : cpu8_mem_model

// >>> testbench/testbench.sv
// self-checking bench for the core subset: alu ops, stack, break, stop
// assumes cpu8_pkg, cpu8_core and the memory model are compiled first
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
 $display("BAD t=%0t got %h exp %h", $time, a, e); end end
module testbench;
   logic        clk_sys_in = 0;
   logic        reset_in   = 1;
   logic        op_valid, ext_irq, brk, mon, from_stack, ce, pc_ld;
   logic [7:0]  opcode, opnd, mem_rd, acc, x, h, ir, pass_code, wdata;
   logic        busy, mem_we, clk_en, in_brk, pass_op;
   logic [15:0] sp, pc, addr;
   logic [5:0]  flags;
   int          fails       = 0;
   int          check_count = 0;
   always #10 clk_sys_in = ~clk_sys_in;
   // ==========================================
   // design and bus partner
   cpu8_core #(.STAB_CYCLES(4)) dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
      .ce_in(ce), .op_valid_in(op_valid), .opcode_in(opcode), .prefix_in(1'b0),
      .operand_in(from_stack ? mem_rd : opnd), .ea_in(16'h0000), .ea2_in(16'h0000),
      .last_cycle_in(1'b0), .break_req_in(brk), .monitor_in(mon), .ext_irq_in(ext_irq),
      .busy_out(busy), .acc_out(acc), .x_out(x), .h_out(h), .stack_pointer_out(sp),
      .flags_out(flags), .pc_out(pc), .pc_load_out(pc_ld), .ir_out(ir), .mem_we_out(mem_we),
      .mem_addr_out(addr), .mem_wdata_out(wdata), .cpu_clk_en_out(clk_en),
      .in_break_out(in_brk), .pass_op_out(pass_op), .pass_opcode_out(pass_code));
   cpu8_mem_model mem (.clk_sys_in(clk_sys_in), .we_in(mem_we), .addr_in(addr),
      .wdata_in(wdata), .rd_addr_in(sp + 16'h0001), .rd_data_out(mem_rd));
   // ==========================================
   // shared tasks
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : final_report
   // returns one ns after the taking edge, where pulses are visible
   task automatic issue(input logic [7:0] code, input logic [7:0] val);
      @(posedge clk_sys_in) #1;
      op_valid = 1;
      opcode = code;
      opnd = val;
      @(posedge clk_sys_in) #1;
      op_valid = 0;
   endtask : issue
   // busy follows the state one edge late, so let one edge pass before trusting it
   task automatic settle;
      int n = 0;
      @(posedge clk_sys_in) #1;
      while (busy !== 1'b0 && n < 40) begin
         @(posedge clk_sys_in) #1;
         n++;
      end
      if (n == 40) begin
         fails++;
         final_report();
      end
   endtask : settle
   // ==========================================
   // scenarios
   task automatic t_alu;
      issue(cpu8_pkg::OP_ORA_IMM, 8'h96); settle();
      `CHK({acc, flags}, {8'h96, 6'h0C})
      issue(cpu8_pkg::OP_NSA, 8'h00); settle();
      `CHK({acc, flags}, {8'h69, 6'h0C})
      issue(cpu8_pkg::OP_LSR_A, 8'h00); settle();
      `CHK({acc, flags}, {8'h34, 6'h29})
      issue(cpu8_pkg::OP_ROL_A, 8'h00); settle();
      `CHK({acc, flags}, {8'h69, 6'h08})
      issue(cpu8_pkg::OP_NEG_A, 8'h00); settle();
      `CHK({acc, flags}, {8'h97, 6'h0D})
      issue(cpu8_pkg::OP_PUSH_ACCUMULATOR_OP, 8'h00);
      `CHK({mem_we, addr, wdata}, {1'b1, 16'h00FF, 8'h97})
      settle();
      `CHK({sp, flags}, {16'h00FE, 6'h0D})
      from_stack = 1;
      issue(cpu8_pkg::OP_PULL_INDEX_LOW_OP, 8'h00); settle();
      from_stack = 0;
      `CHK({sp, x}, {16'h00FF, 8'h97})
      issue(cpu8_pkg::OP_MUL, 8'h00); settle();
      `CHK({x, acc, flags}, {8'h59, 8'h11, 6'h0C})
      $display("alu and stack test done");
   endtask : t_alu
   task automatic t_pass;
      issue(8'h9D, 8'h55);
      `CHK({pass_op, pass_code, acc, x, h}, {1'b1, 8'h9D, 8'h11, 8'h59, 8'h00})
      issue(cpu8_pkg::OP_MOV_DIX, 8'h5A);
      `CHK({mem_we, addr, wdata}, {1'b1, 16'h0000, 8'h5A})
      settle();
      `CHK({h, x, flags}, {8'h00, 8'h5A, 6'h08})
      ce = 0;
      issue(cpu8_pkg::OP_NSA, 8'h00);
      ce = 1;
      `CHK({acc, busy}, {8'h11, 1'b0})
      $display("pass-through test done");
   endtask : t_pass
   task automatic t_break;
      for (int m = 0; m < 2; m++) begin
         @(posedge clk_sys_in) #1;
         brk = 1;
         mon = m[0];
         @(posedge clk_sys_in) #1;
         `CHK({ir, in_brk, pc_ld}, {cpu8_pkg::OP_SWI, 1'b1, 1'b1})
         `CHK(pc, m ? cpu8_pkg::VEC_BREAK_MON : cpu8_pkg::VEC_BREAK)
         issue(cpu8_pkg::OP_RTI, 8'h00); settle();
         `CHK(in_brk, 1'b1)
         brk = 0;
         issue(cpu8_pkg::OP_RTI, 8'h00); settle();
         `CHK(in_brk, 1'b0)
      end
      $display("break test done");
   endtask : t_break
   task automatic t_stop;
      int n = 0;
      issue(cpu8_pkg::OP_STOP, 8'h00);
      `CHK({clk_en, flags[cpu8_pkg::FL_I]}, 2'h0)
      ext_irq = 1;
      while (clk_en !== 1'b1 && n < 40) begin
         @(posedge clk_sys_in) #1;
         n++;
      end
      ext_irq = 0;
      `CHK(n >= 4 && n < 40, 1'b1)
      if (n == 40) final_report();
      `CHK(flags[cpu8_pkg::FL_I], 1'b0)
      settle();
      issue(cpu8_pkg::OP_STOP, 8'h00);
      reset_in = 1;
      @(posedge clk_sys_in) #1;
      reset_in = 0;
      `CHK({clk_en, flags[cpu8_pkg::FL_I]}, 2'h3)
      $display("stop test done");
   endtask : t_stop
   // ==========================================
   // main sequence
   initial begin
      op_valid = 0;
      opcode = 8'h00;
      opnd = 8'h00;
      {ext_irq, brk, mon, from_stack} = 4'h0;
      ce = 1;
      repeat (3) @(posedge clk_sys_in);
      #1 reset_in = 0;
      t_alu();
      t_pass();
      t_break();
      t_stop();
      final_report();
   end
endmodule : testbench
